/* pcc_pkg.sv */
// Package with constants shared by the pulse contact counter files.
package pcc_pkg;
  // System clock rate and derived millisecond prescale.
  localparam int unsigned CLK_HZ = 125_000_000; // Clock rate in Hz.
  localparam int unsigned MS_CYC_DEF = CLK_HZ / 1000; // Clock cycles per millisecond.
  localparam int unsigned MS_CNT_W = 17; // Width of the millisecond prescaler.

  // Highest pulse rates that each source setting must follow.
  localparam int unsigned MECH_MAX_HZ = 25; // Mechanical contact rate limit.
  localparam int unsigned ELEC_MAX_HZ = 100; // Electronic contact rate limit.
  // Debounce window is one eighth of the shortest pulse period, in ms.
  localparam int unsigned DEB_MECH_MS = 1000 / (MECH_MAX_HZ * 8); // Mechanical window.
  localparam int unsigned DEB_ELEC_MS = 1000 / (ELEC_MAX_HZ * 8); // Electronic window.
  localparam int unsigned DEB_W = 4; // Width of the debounce counter.

  // Indicator hold time in ms.
  localparam int unsigned HOLD_MS = 100; // Least time an indicator state stands.
  localparam int unsigned HOLD_W = 7; // Width of the hold counter.

  // Buffering during communication loss.
  localparam int unsigned BUF_PERIOD_MIN = 15; // Buffering period in minutes.
  localparam int unsigned BUF_PERIOD_MS_DEF = BUF_PERIOD_MIN * 60 * 1000; // Period in ms.
  localparam int unsigned BUF_SPAN_DAYS = 3; // Longest buffering span in days.
  localparam int unsigned BUF_MAX_WR = BUF_SPAN_DAYS * 24 * 60 / BUF_PERIOD_MIN; // Writes.
  localparam int unsigned BUF_TMR_W = 20; // Width of the buffering timer.
  localparam int unsigned BUF_N_W = 9; // Width of the write counter.

  // Legacy bus view of the count.
  localparam int unsigned LEGACY_W = 6; // Legacy count width, 64 units.

  // Start-up settling, long enough for the two-stage synchronisers.
  localparam logic [1:0] SETTLE_CYC = 2'h3; // Cycles before the strap is trusted.

  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00; // Control.
  localparam logic [7:0] OFS_COUNT = 8'h04; // Accumulator, read only.
  localparam logic [7:0] OFS_LEGACY = 8'h08; // Six-bit legacy count, read only.
  localparam logic [7:0] OFS_OPERAND = 8'h0c; // Correction or preset operand.
  localparam logic [7:0] OFS_CMD = 8'h10; // Command strobes, write only.
  localparam logic [7:0] OFS_THRESH = 8'h14; // Report change threshold.
  localparam logic [7:0] OFS_INTERVAL = 8'h18; // Report interval in ms.
  localparam logic [7:0] OFS_STATUS = 8'h1c; // Status.
  localparam logic [7:0] OFS_REPORTED = 8'h20; // Last reported value, read only.
  localparam logic [7:0] OFS_BUFN = 8'h24; // Buffer writes in this loss, read only.

  // Control fields.
  localparam int unsigned CTRL_SRC_BIT = 0; // 1 selects electronic source.
  localparam int unsigned CTRL_LAST_BIT = 1; // 1 selects restore of last value.
  localparam logic [1:0] CTRL_RST = 2'h0; // Control reset value.

  // Command fields.
  localparam int unsigned CMD_CLEAR_BIT = 0; // Clear accumulator.
  localparam int unsigned CMD_PRESET_BIT = 1; // Load operand.
  localparam int unsigned CMD_ADD_BIT = 2; // Add operand.
  localparam int unsigned CMD_SUB_BIT = 3; // Subtract operand.

  // Status fields.
  localparam int unsigned ST_LEVEL_BIT = 0; // Debounced input level.
  localparam int unsigned ST_REP_BIT = 1; // Sticky report sent, write 1 clears.
  localparam int unsigned ST_OVR_BIT = 2; // Sticky override press, write 1 clears.
  localparam int unsigned ST_COMM_BIT = 3; // Communication good.
  localparam int unsigned ST_RUN_BIT = 4; // Start-up finished.

  // Start-up states.
  typedef enum logic {PCC_SETTLE, PCC_RUN} pcc_state_t;
endpackage : pcc_pkg

/* pcc_deb_if.sv */
// Interface between the counter core and its debouncer.
`timescale 1ns/1ps
interface pcc_deb_if;
  logic tick; // Millisecond tick.
  logic sample; // Synchronised raw contact.
  logic [pcc_pkg::DEB_W-1:0] limit; // Debounce window in ms.
  logic level; // Debounced level.
  logic rise; // One-cycle closing edge.
  modport deb (input tick, input sample, input limit, output level, output rise);
  modport user (output tick, output sample, output limit, input level, input rise);
endinterface : pcc_deb_if

/* pcc_debounce.sv */
// Contact debouncer that passes a level only after it stays stable.
`timescale 1ns/1ps
module pcc_debounce (
  input wire logic i_clk_sys, // System clock.
  input wire logic i_rst_n, // Asynchronous reset, active low.
  pcc_deb_if.deb dbi // Link to the counter core.
);
  logic level_r; // Accepted level.
  logic level_nxt; // Next accepted level.
  logic rise_r; // Closing edge pulse.
  logic rise_nxt; // Next closing edge pulse.
  logic [pcc_pkg::DEB_W-1:0] cnt_r; // Stable time seen so far.
  logic [pcc_pkg::DEB_W-1:0] cnt_nxt; // Next stable time.

  // A disagreeing sample must persist for the whole window; any bounce back restarts it.
  always_comb begin
    level_nxt = level_r;
    rise_nxt = 1'b0;
    cnt_nxt = cnt_r;
    if (dbi.sample == level_r) begin
      cnt_nxt = '0;
    end else if (cnt_r >= dbi.limit) begin
      level_nxt = dbi.sample;
      rise_nxt = dbi.sample;
      cnt_nxt = '0;
    end else if (dbi.tick) begin
      cnt_nxt = cnt_r + 4'h1;
    end
  end

  // Registers of the debouncer.
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      level_r <= 1'b0;
      rise_r <= 1'b0;
      cnt_r <= '0;
    end else begin
      level_r <= level_nxt;
      rise_r <= rise_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign dbi.level = level_r;
  assign dbi.rise = rise_r;
endmodule : pcc_debounce

/* pcc_top.sv */
// Pulse contact counter with debouncer, corrections, buffering and reporting.
// Summary of operation
// - Debounce the contact before counting.
// - Count closing edges only, ignore openings.
// - Mechanical source follows pulses up to 25 Hz.
// - Electronic source follows pulses up to 100 Hz.
// - Thirty-two bit accumulator is the process value.
// - Legacy view is six bits; master polls often.
// - Clear, add, subtract or preset the accumulator.
// - Reset power-up mode starts from zero.
// - Last-value mode restores from the buffered copy.
// - Reports follow threshold and interval settings.
// - Counting and indicator continue during communication loss.
// - In last-value mode, buffer at loss, then every 15 min, 3 days.
// - Override button ignored; pressing shows an error.
// - Status indicator follows the debounced input.
// - Counter icon stays lit; three segments advance per pulse.
// - Indicator states stand at least 100 ms.
//
// The register offsets and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ps
module pcc_top #(
  parameter int unsigned MS_CYC = pcc_pkg::MS_CYC_DEF, // Cycles per millisecond.
  parameter int unsigned BUF_PERIOD_MS = pcc_pkg::BUF_PERIOD_MS_DEF // Buffer period in ms.
) (
  input wire logic i_clk_sys, // System clock, 125 MHz.
  input wire logic i_rst_n, // Asynchronous reset, active low.
  input wire logic [7:0] i_avs_address, // Register byte address.
  input wire logic i_avs_read, // Read request.
  input wire logic i_avs_write, // Write request.
  input wire logic [31:0] i_avs_writedata, // Write data.
  input wire logic [3:0] i_avs_byteenable, // Write byte lanes.
  output logic [31:0] o_avs_readdata, // Read data.
  output logic o_avs_waitrequest, // Wait request.
  input wire logic i_contact, // Raw field contact, high when closed.
  input wire logic i_comm_ok, // Island bus communication is alive.
  input wire logic i_override_btn, // Local override button, high when pressed.
  input wire logic i_powerup_last, // Power-up strap, high selects last value.
  input wire logic [31:0] i_nv_count, // Buffered copy read from non-volatile store.
  output logic o_nv_wr, // Pulse: store o_nv_data in the buffer.
  output logic [31:0] o_nv_data, // Value to buffer.
  output logic o_report, // Pulse: send o_report_value to the master.
  output logic [31:0] o_report_value, // Reported count.
  output logic o_status_led, // Point status indicator.
  output logic [2:0] o_seg, // Three display segments.
  output logic o_counter_icon, // Counter symbol on the display.
  output logic o_override_err // Override error indication.
);
  localparam logic [31:0] MAX_COUNT = 32'hffffffff; // Largest accumulator value.

  // Two-stage synchronisers for everything coming from pins.
  logic raw_s1, raw_s2; // Contact.
  logic comm_s1, comm_s2; // Communication good.
  logic ovr_s1, ovr_s2; // Override button.
  logic mode_s1, mode_s2; // Power-up strap.
  logic [31:0] nv_s1, nv_s2; // Buffered copy.

  // The first stage of each synchroniser feeds only the second.
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {raw_s1, raw_s2, comm_s1, comm_s2} <= 4'h0;
      {ovr_s1, ovr_s2, mode_s1, mode_s2} <= 4'h0;
      nv_s1 <= 32'h0;
      nv_s2 <= 32'h0;
    end else begin
      {raw_s1, comm_s1, ovr_s1, mode_s1} <= {i_contact, i_comm_ok, i_override_btn, i_powerup_last};
      {raw_s2, comm_s2, ovr_s2, mode_s2} <= {raw_s1, comm_s1, ovr_s1, mode_s1};
      nv_s1 <= i_nv_count;
      nv_s2 <= nv_s1;
    end
  end

  // Millisecond prescaler; all long times are counted in its ticks.
  logic [pcc_pkg::MS_CNT_W-1:0] ms_cnt_r, ms_cnt_nxt; // Prescale count.
  logic tick_r, tick_nxt; // One-cycle millisecond tick.

  always_comb begin
    tick_nxt = 1'b0;
    ms_cnt_nxt = ms_cnt_r + 17'h1;
    if (ms_cnt_r == pcc_pkg::MS_CNT_W'(MS_CYC - 1)) begin
      ms_cnt_nxt = '0;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ms_cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      ms_cnt_r <= ms_cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  // Control and operand registers, held in the counter group below.
  logic [1:0] ctrl_r, ctrl_nxt; // Source select and power-up mode.
  logic [31:0] operand_r, operand_nxt; // Correction or preset operand.
  logic [31:0] thresh_r, thresh_nxt; // Report change threshold.
  logic [31:0] ivl_r, ivl_nxt; // Report interval in ms.

  // Debouncer; the window follows the selected pulse source.
  pcc_deb_if dbi ();
  assign dbi.tick = tick_r;
  assign dbi.sample = raw_s2;
  assign dbi.limit = ctrl_r[pcc_pkg::CTRL_SRC_BIT] ? pcc_pkg::DEB_W'(pcc_pkg::DEB_ELEC_MS)
                                                   : pcc_pkg::DEB_W'(pcc_pkg::DEB_MECH_MS);

  pcc_debounce u_deb (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .dbi(dbi)
  );

  // Bus slave: one wait cycle, then a single cycle with waitrequest low.
  logic wait_r, wait_nxt; // Registered waitrequest.
  logic [31:0] rdata_r, rdata_nxt; // Registered read data.
  logic wr_fire; // Write takes effect in this cycle.
  logic [31:0] wmask; // Byte lanes expanded to bits.
  logic [31:0] stat_w; // Status word.
  logic rep_pend_r, ovr_pend_r; // Sticky status flags.
  logic [31:0] count_r; // Accumulator.
  logic [31:0] last_rep_r; // Value of the last report.
  logic [pcc_pkg::BUF_N_W-1:0] buf_n_r; // Buffer writes in this loss.
  pcc_pkg::pcc_state_t st_r; // Start-up state.

  always_comb begin
    stat_w = 32'h0;
    stat_w[pcc_pkg::ST_LEVEL_BIT] = dbi.level;
    stat_w[pcc_pkg::ST_REP_BIT] = rep_pend_r;
    stat_w[pcc_pkg::ST_OVR_BIT] = ovr_pend_r;
    stat_w[pcc_pkg::ST_COMM_BIT] = comm_s2;
    stat_w[pcc_pkg::ST_RUN_BIT] = (st_r == pcc_pkg::PCC_RUN);
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{i_avs_byteenable[b]}};
    end
    wr_fire = i_avs_write && !wait_r;
    wait_nxt = !((i_avs_read || i_avs_write) && wait_r);
    rdata_nxt = 32'h0;
    // Read data is latched in the wait cycle; unmapped addresses read zero.
    if (i_avs_address == pcc_pkg::OFS_CTRL) begin
      rdata_nxt = {30'h0, ctrl_r};
    end else if (i_avs_address == pcc_pkg::OFS_COUNT) begin
      rdata_nxt = count_r;
    end else if (i_avs_address == pcc_pkg::OFS_LEGACY) begin
      rdata_nxt = {26'h0, count_r[pcc_pkg::LEGACY_W-1:0]};
    end else if (i_avs_address == pcc_pkg::OFS_OPERAND) begin
      rdata_nxt = operand_r;
    end else if (i_avs_address == pcc_pkg::OFS_THRESH) begin
      rdata_nxt = thresh_r;
    end else if (i_avs_address == pcc_pkg::OFS_INTERVAL) begin
      rdata_nxt = ivl_r;
    end else if (i_avs_address == pcc_pkg::OFS_STATUS) begin
      rdata_nxt = stat_w;
    end else if (i_avs_address == pcc_pkg::OFS_REPORTED) begin
      rdata_nxt = last_rep_r;
    end else if (i_avs_address == pcc_pkg::OFS_BUFN) begin
      rdata_nxt = {23'h0, buf_n_r};
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wait_r <= 1'b1;
      rdata_r <= 32'h0;
    end else begin
      wait_r <= wait_nxt;
      rdata_r <= (i_avs_read && wait_r) ? rdata_nxt : rdata_r;
    end
  end

  // Accumulator, configuration and start-up sequencing.
  logic [31:0] count_nxt; // Next accumulator value.
  logic [32:0] sum; // Saturating add helper.
  logic [1:0] settle_r, settle_nxt; // Start-up settle counter.
  pcc_pkg::pcc_state_t st_nxt; // Next start-up state.
  logic [3:0] cmd; // Command bits of the current write.

  always_comb begin
    count_nxt = count_r;
    ctrl_nxt = ctrl_r;
    operand_nxt = operand_r;
    thresh_nxt = thresh_r;
    ivl_nxt = ivl_r;
    settle_nxt = settle_r;
    st_nxt = st_r;
    sum = {1'b0, count_r} + {1'b0, operand_r};
    cmd = 4'h0;
    if (wr_fire && i_avs_address == pcc_pkg::OFS_CTRL) begin
      ctrl_nxt = (ctrl_r & ~wmask[1:0]) | (i_avs_writedata[1:0] & wmask[1:0]);
    end else if (wr_fire && i_avs_address == pcc_pkg::OFS_OPERAND) begin
      operand_nxt = (operand_r & ~wmask) | (i_avs_writedata & wmask);
    end else if (wr_fire && i_avs_address == pcc_pkg::OFS_THRESH) begin
      thresh_nxt = (thresh_r & ~wmask) | (i_avs_writedata & wmask);
    end else if (wr_fire && i_avs_address == pcc_pkg::OFS_INTERVAL) begin
      ivl_nxt = (ivl_r & ~wmask) | (i_avs_writedata & wmask);
    end else if (wr_fire && i_avs_address == pcc_pkg::OFS_CMD && i_avs_byteenable[0]) begin
      cmd = i_avs_writedata[3:0];
    end
    case (st_r)
      pcc_pkg::PCC_SETTLE: begin
        // The strap and the buffered copy are trusted only once the synchronisers have filled.
        settle_nxt = settle_r + 2'h1;
        if (settle_r == pcc_pkg::SETTLE_CYC) begin
          st_nxt = pcc_pkg::PCC_RUN;
          ctrl_nxt[pcc_pkg::CTRL_LAST_BIT] = mode_s2;
          count_nxt = mode_s2 ? nv_s2 : 32'h0;
        end
      end
      default: begin
        // Commands first, then the pulse of the same cycle on top, so neither is lost.
        if (cmd[pcc_pkg::CMD_CLEAR_BIT]) begin
          count_nxt = 32'h0;
        end else if (cmd[pcc_pkg::CMD_PRESET_BIT]) begin
          count_nxt = operand_r;
        end else if (cmd[pcc_pkg::CMD_ADD_BIT]) begin
          count_nxt = sum[32] ? MAX_COUNT : sum[31:0];
        end else if (cmd[pcc_pkg::CMD_SUB_BIT]) begin
          count_nxt = (operand_r > count_r) ? 32'h0 : count_r - operand_r;
        end
        // Counting ignores the override button and communication state.
        if (dbi.rise && count_nxt != MAX_COUNT) begin
          count_nxt = count_nxt + 32'h1;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_r <= 32'h0;
      ctrl_r <= pcc_pkg::CTRL_RST;
      operand_r <= 32'h0;
      thresh_r <= 32'h0;
      ivl_r <= 32'h0;
      settle_r <= 2'h0;
      st_r <= pcc_pkg::PCC_SETTLE;
    end else begin
      count_r <= count_nxt;
      ctrl_r <= ctrl_nxt;
      operand_r <= operand_nxt;
      thresh_r <= thresh_nxt;
      ivl_r <= ivl_nxt;
      settle_r <= settle_nxt;
      st_r <= st_nxt;
    end
  end

  // Change-of-value and interval reporting, only while communication is good.
  logic [31:0] last_rep_nxt, ivl_cnt_r, ivl_cnt_nxt, diff; // Report tracking.
  logic rep_r, rep_nxt, rep_pend_nxt, ovr_pend_nxt; // Report pulse and sticky flags.
  logic [31:0] rep_val_r, rep_val_nxt; // Reported value.
  logic clr_rep, clr_ovr; // Write-one-to-clear strobes.

  always_comb begin
    last_rep_nxt = last_rep_r;
    rep_val_nxt = rep_val_r;
    rep_nxt = 1'b0;
    ivl_cnt_nxt = ivl_cnt_r;
    diff = (count_r >= last_rep_r) ? count_r - last_rep_r : last_rep_r - count_r;
    clr_rep = wr_fire && i_avs_address == pcc_pkg::OFS_STATUS && i_avs_byteenable[0]
              && i_avs_writedata[pcc_pkg::ST_REP_BIT];
    clr_ovr = wr_fire && i_avs_address == pcc_pkg::OFS_STATUS && i_avs_byteenable[0]
              && i_avs_writedata[pcc_pkg::ST_OVR_BIT];
    if (tick_r && ivl_cnt_r != MAX_COUNT) begin
      ivl_cnt_nxt = ivl_cnt_r + 32'h1;
    end
    if (comm_s2 && st_r == pcc_pkg::PCC_RUN
        && ((thresh_r != 32'h0 && diff >= thresh_r)
            || (ivl_r != 32'h0 && ivl_cnt_r >= ivl_r))) begin
      rep_nxt = 1'b1;
      rep_val_nxt = count_r;
      last_rep_nxt = count_r;
      ivl_cnt_nxt = 32'h0;
    end
    // A new event wins over a clear in the same cycle.
    rep_pend_nxt = rep_nxt || (rep_pend_r && !clr_rep);
    ovr_pend_nxt = ovr_s2 || (ovr_pend_r && !clr_ovr);
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      last_rep_r <= 32'h0;
      rep_val_r <= 32'h0;
      rep_r <= 1'b0;
      ivl_cnt_r <= 32'h0;
      rep_pend_r <= 1'b0;
      ovr_pend_r <= 1'b0;
    end else begin
      last_rep_r <= last_rep_nxt;
      rep_val_r <= rep_val_nxt;
      rep_r <= rep_nxt;
      ivl_cnt_r <= ivl_cnt_nxt;
      rep_pend_r <= rep_pend_nxt;
      ovr_pend_r <= ovr_pend_nxt;
    end
  end

  // Buffering during loss; flash wear is why the writes are capped.
  logic comm_q_r; // Previous communication state.
  logic [pcc_pkg::BUF_TMR_W-1:0] buf_tmr_r, buf_tmr_nxt; // Ms since last buffer write.
  logic [pcc_pkg::BUF_N_W-1:0] buf_n_nxt; // Next write count.
  logic nv_wr_r, nv_wr_nxt; // Buffer write pulse.
  logic [31:0] nv_data_r, nv_data_nxt; // Buffer write data.
  logic restore_mode; // Last-value power-up mode selected.

  always_comb begin
    restore_mode = ctrl_r[pcc_pkg::CTRL_LAST_BIT];
    buf_tmr_nxt = buf_tmr_r;
    buf_n_nxt = buf_n_r;
    nv_wr_nxt = 1'b0;
    nv_data_nxt = nv_data_r;
    if (comm_s2) begin
      buf_n_nxt = '0;
      buf_tmr_nxt = '0;
    end else if (comm_q_r && restore_mode && st_r == pcc_pkg::PCC_RUN) begin
      nv_wr_nxt = 1'b1;
      nv_data_nxt = count_r;
      buf_n_nxt = 9'h1;
      buf_tmr_nxt = '0;
    end else if (restore_mode && buf_n_r != 9'h0
                 && buf_n_r < pcc_pkg::BUF_N_W'(pcc_pkg::BUF_MAX_WR) && tick_r) begin
      buf_tmr_nxt = buf_tmr_r + 20'h1;
      if (buf_tmr_r == pcc_pkg::BUF_TMR_W'(BUF_PERIOD_MS - 1)) begin
        nv_wr_nxt = 1'b1;
        nv_data_nxt = count_r;
        buf_n_nxt = buf_n_r + 9'h1;
        buf_tmr_nxt = '0;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      comm_q_r <= 1'b0;
      buf_tmr_r <= '0;
      buf_n_r <= '0;
      nv_wr_r <= 1'b0;
      nv_data_r <= 32'h0;
    end else begin
      comm_q_r <= comm_s2;
      buf_tmr_r <= buf_tmr_nxt;
      buf_n_r <= buf_n_nxt;
      nv_wr_r <= nv_wr_nxt;
      nv_data_r <= nv_data_nxt;
    end
  end

  // Indicators: wanted state is shown only after the previous one stood its hold time.
  logic [2:0] seg_pos_r, seg_pos_nxt; // Segment pattern that advances per pulse.
  logic [4:0] disp_r, disp_nxt, want; // Shown and wanted {err, seg, led}.
  logic [pcc_pkg::HOLD_W-1:0] hold_r, hold_nxt; // Ms the shown state has stood.
  logic icon_r; // Counter symbol.

  always_comb begin
    seg_pos_nxt = dbi.rise ? {seg_pos_r[1:0], seg_pos_r[2]} : seg_pos_r;
    want = {ovr_s2, seg_pos_r, dbi.level};
    disp_nxt = disp_r;
    hold_nxt = hold_r;
    if (disp_r != want && hold_r >= pcc_pkg::HOLD_W'(pcc_pkg::HOLD_MS)) begin
      disp_nxt = want;
      hold_nxt = '0;
    end else if (tick_r && hold_r < pcc_pkg::HOLD_W'(pcc_pkg::HOLD_MS)) begin
      hold_nxt = hold_r + 7'h1;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      seg_pos_r <= 3'h1;
      disp_r <= 5'h2;
      hold_r <= '0;
      icon_r <= 1'b0;
    end else begin
      seg_pos_r <= seg_pos_nxt;
      disp_r <= disp_nxt;
      hold_r <= hold_nxt;
      icon_r <= 1'b1;
    end
  end

  assign o_avs_readdata = rdata_r;
  assign o_avs_waitrequest = wait_r;
  assign o_nv_wr = nv_wr_r;
  assign o_nv_data = nv_data_r;
  assign o_report = rep_r;
  assign o_report_value = rep_val_r;
  assign o_status_led = disp_r[0];
  assign o_seg = disp_r[3:1];
  assign o_counter_icon = icon_r;
  assign o_override_err = disp_r[4];
endmodule : pcc_top

/* pcc_top_asserts.sv */
// Checker of the pulse contact counter's port behaviour.
`timescale 1ns/1ps
module pcc_top_asserts (
  input wire logic i_clk_sys, // Clock.
  input wire logic i_rst_n, // Reset, active low.
  input wire logic i_avs_read, // Read request.
  input wire logic i_avs_write, // Write request.
  input wire logic o_avs_waitrequest, // Wait request.
  input wire logic o_nv_wr, // Buffer write pulse.
  input wire logic [31:0] o_nv_data, // Buffered value.
  input wire logic o_report, // Report pulse.
  input wire logic [31:0] o_report_value, // Reported value.
  input wire logic o_status_led, // Indicator.
  input wire logic [2:0] o_seg, // Segments.
  input wire logic o_counter_icon // Counter icon.
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  // A bus answer stands one cycle, and only a request brings one.
  wait_one_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("wait low too long");
  idle_wait_a: assert property (!(i_avs_read || i_avs_write) |=> o_avs_waitrequest)
    else $error("answer without request");
  nv_pulse_a: assert property (o_nv_wr |=> !o_nv_wr)
    else $error("buffer write too long");
  nv_hold_a: assert property (!o_nv_wr |-> $stable(o_nv_data))
    else $error("buffer data moved");
  rep_pulse_a: assert property (o_report |=> !o_report)
    else $error("report too long");
  rep_hold_a: assert property (!o_report |-> $stable(o_report_value))
    else $error("report value moved");
  // Eight cycles is far below the real hold, so any short flicker is caught.
  led_hold_a: assert property ($changed(o_status_led) |=> $stable(o_status_led)[*8])
    else $error("indicator not held");
  // The hold time can let several pulses pass between shown states; on three segments that shows as one or two steps.
  seg_step_a: assert property ($changed(o_seg) |->
    o_seg == 3'({$past(o_seg), $past(o_seg)} >> 2)
    || o_seg == 3'({$past(o_seg), $past(o_seg)} >> 1)) else $error("segments not rotated");
  icon_on_a: assert property (i_rst_n |=> o_counter_icon)
    else $error("counter icon off");
endmodule : pcc_top_asserts

bind pcc_top pcc_top_asserts u_chk (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest),
  .o_nv_wr(o_nv_wr), .o_nv_data(o_nv_data), .o_report(o_report),
  .o_report_value(o_report_value), .o_status_led(o_status_led), .o_seg(o_seg),
  .o_counter_icon(o_counter_icon));

/* pcc_contact_model.sv */
// Field meter contact that bounces at every closing and opening.
`timescale 1ns/1ps
module pcc_contact_model (
  input wire logic i_clk_sys, // Bench clock.
  output logic o_contact // Contact level, high when closed.
);
  initial o_contact = 1'b0;
  // Three bounce cycles per edge, then the level holds; hold sets the rate.
  task automatic burst(input int n, input int hold);
    repeat (n) begin
      for (int i = 0; i < 3; i++) @(posedge i_clk_sys) o_contact <= ~i[0];
      repeat (hold) @(posedge i_clk_sys);
      for (int i = 0; i < 3; i++) @(posedge i_clk_sys) o_contact <= i[0];
      repeat (hold) @(posedge i_clk_sys);
    end
  endtask : burst
endmodule : pcc_contact_model

/* tb_pulse_contact_counter.sv */
// Self-checking bench of the pulse contact counter.
`timescale 1ns/1ps
module tb_pulse_contact_counter;
  logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, comm = 1'b1, btn = 1'b0, strap = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0, nvc = 32'h55, rdq, q, nvd, rv, rep_v = 32'h0;
  logic wq, nvw, rep, led, icon, oerr, contact;
  logic [2:0] seg;
  int err_count = 0, n_tests = 0, cyc = 0, nv_n = 0;
  // Command rows: strobe, operand, expected count; the last row tests priority.
  logic [3:0] cmd [6] = '{4'h2, 4'h4, 4'h8, 4'h2, 4'h4, 4'h3};
  logic [31:0] opd [6] = '{32'h5, 32'h3, 32'ha, 32'hffffffff, 32'h1, 32'h9};
  logic [31:0] exp_c [6] = '{32'h5, 32'h8, 32'h0, 32'hffffffff, 32'hffffffff, 32'h0};
  always #4 clk = ~clk;
  // Keep the last reported value and count the buffer write pulses.
  always @(posedge clk) if (rep) rep_v <= rv;
  always @(posedge clk) if (nvw) nv_n++;
  pcc_contact_model u_src (.i_clk_sys(clk), .o_contact(contact));
  pcc_top #(.MS_CYC(10), .BUF_PERIOD_MS(20)) u_dut (.i_clk_sys(clk), .i_rst_n(rst_n),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
    .i_avs_byteenable(4'hf), .o_avs_readdata(q), .o_avs_waitrequest(wq), .i_contact(contact),
    .i_comm_ok(comm), .i_override_btn(btn), .i_powerup_last(strap), .i_nv_count(nvc),
    .o_nv_wr(nvw), .o_nv_data(nvd), .o_report(rep), .o_report_value(rv), .o_status_led(led),
    .o_seg(seg), .o_counter_icon(icon), .o_override_err(oerr));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] t=%0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  // One bus cycle, held until waitrequest is seen low.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clk);
    rd <= ~w;
    wr <= w;
    adr <= a;
    wd <= d;
    do @(posedge clk); while (wq !== 1'b0);
    r = q;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  // The run needs about 3000 cycles; a hang is cut off well after that.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      stop_test;
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    bus(1'b0, 8'h04, 32'h0, rdq);
    chk(rdq, 32'h0);
    chk(32'(seg), 32'h1);
    chk(32'(icon), 32'h1);
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, 8'h0c, opd[i], rdq);
      bus(1'b1, 8'h10, 32'(cmd[i]), rdq);
      bus(1'b0, 8'h04, 32'h0, rdq);
      chk(rdq, exp_c[i]);
      bus(1'b0, 8'h08, 32'h0, rdq);
      chk(rdq, 32'(exp_c[i][5:0]));
    end
    $display("commands done");
    // Pulses near the highest rate of each source: 106 and 406 cycles a period.
    bus(1'b1, 8'h00, 32'h1, rdq);
    u_src.burst(3, 50);
    bus(1'b0, 8'h04, 32'h0, rdq);
    chk(rdq, 32'h3);
    bus(1'b1, 8'h00, 32'h0, rdq);
    u_src.burst(2, 200);
    bus(1'b0, 8'h04, 32'h0, rdq);
    chk(rdq, 32'h5);
    $display("pulses done");
    bus(1'b1, 8'h18, 32'h5, rdq);
    repeat (100) @(posedge clk);
    chk(rep_v, 32'h5);
    bus(1'b1, 8'h18, 32'h0, rdq);
    bus(1'b1, 8'h14, 32'h1, rdq);
    u_src.burst(1, 50);
    chk(rep_v, 32'h6);
    $display("reporting done");
    bus(1'b1, 8'h00, 32'h3, rdq);
    comm <= 1'b0;
    repeat (40) @(posedge clk);
    chk(nvd, 32'h6);
    chk(nv_n, 32'h1);
    u_src.burst(1, 50);
    repeat (250) @(posedge clk);
    chk(nvd, 32'h7);
    comm <= 1'b1;
    btn <= 1'b1;
    repeat (1100) @(posedge clk);
    chk(32'(oerr), 32'h1);
    chk(32'(led), 32'h0);
    bus(1'b0, 8'h04, 32'h0, rdq);
    chk(rdq, 32'h7);
    $display("loss done");
    btn <= 1'b0;
    strap <= 1'b1;
    nvc <= 32'h1234;
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    bus(1'b0, 8'h04, 32'h0, rdq);
    chk(rdq, 32'h1234);
    $display("power-up done");
    stop_test;
  end
endmodule : tb_pulse_contact_counter
